// file: hdl/isr_pkg.sv
// constants shared by the serial-audio receive path
package isr_pkg;

  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned MCLK_HZ      = 24_576_000;
  localparam int unsigned SAMPLE_HZ    = 48_000;
  localparam int unsigned MCLK_RATIO   = 512;
  localparam int unsigned BCLK_HZ      = 3_072_000;

  localparam logic [31:0] MCLK_INC =
    32'((64'(MCLK_HZ) << 32) / 64'(CLK_HZ));

  localparam int unsigned ADC_RST_NS   = 1000;
  localparam int unsigned ADC_RST_CYC  =
    (ADC_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0]  ADC_RST_LAST = 8'(ADC_RST_CYC - 1);

  localparam int unsigned FRAME_BITS   = 64;
  localparam int unsigned FIELD_BITS   = 32;
  localparam int unsigned SAMPLE_BITS  = 24;
  localparam logic [4:0]  DATA_FIRST   = 5'h01;
  localparam logic [4:0]  DATA_LAST    = 5'h18;

  localparam int unsigned BLOCK_PAIRS  = 32;
  localparam logic [4:0]  BLOCK_LAST   = 5'h1f;
  localparam logic [1:0]  DECIM_LAST   = 2'h3;
  localparam logic [2:0]  INTERP_LAST  = 3'h3;

  localparam int unsigned IF_HZ        = 12_000;
  localparam int unsigned AUDIO_LO_HZ  = 150;
  localparam int unsigned AUDIO_HI_HZ  = 3_200;
  localparam int unsigned HP_SHIFT     = 6;
  localparam int unsigned LP_SHIFT     = 1;
  localparam int unsigned OUT_LSB      = 2;

  localparam logic        SIDEBAND_RST = 1'b0;

endpackage

// file: hdl/isr_receive_path.sv
// serial-audio receive path: link slave, if mixer, sideband demodulator
// Behaviour
// - converter masters link, we accept bit clock
// - drive master clock from a 32-bit phase step; 24.576 MHz (512 fs) wraps to about 4.576 MHz at the 10 MHz clk
// - 64-bit frame, take 24 of 32
// - we drive the 48 kHz frame clock
// - pulse converter reset once after power-up
// - collect 32 I/Q pairs per block
// - mix to 12 kHz, decimate by four
// - Hilbert shift one path by 90 degrees
// - add or subtract paths for sideband
// - sideband is upper after reset
// - audio filter passes 150 Hz to 3.2 kHz
// - interpolate back to 48 ksps
// - forward output samples in order
// - transmit-enable output drives transmit stage
// - transmitting suspends processing and audio output
`timescale 1ns/1ps

module isr_receive_path
  import isr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic        bitClkPin,
  input  wire logic        serialDataPin,
  input  wire logic        txRequest,
  input  wire logic        sidebandLoad,
  input  wire logic        sidebandLower,
  input  wire logic        audioReady,
  output logic             masterClk,
  output logic             leftRightFrameClock,
  output logic             adcResetN,
  output logic             txDriveEn,
  output logic             audioValid,
  output logic [23:0]      audioData
);

  typedef struct packed {
    logic [2:0]             sclkSync;
    logic [1:0]             sdataSync;
    logic [7:0]             rstCnt;
    logic                   adcResetN;
    logic [31:0]            mclkAcc;
    logic [5:0]             bitCnt;
    logic                   frameClk;
    logic [23:0]            shift;
    logic [23:0]            iHold;
    logic [4:0]             wrIdx;
    logic [31:0][47:0]      blk;
    logic                   blkReady;
    logic                   processing;
    logic [4:0]             rdIdx;
    logic signed [27:0]     accI;
    logic signed [27:0]     accQ;
    logic [6:0][27:0]       qHist;
    logic [2:0][27:0]       iHist;
    logic                   sbLsb;
    logic signed [27:0]     hpX;
    logic signed [27:0]     hpY;
    logic signed [27:0]     lpY;
    logic [23:0]            outSample;
    logic                   emitting;
    logic [2:0]             repCnt;
    logic [23:0]            data0;
    logic [23:0]            data1;
    logic                   valid0;
    logic                   valid1;
    logic                   txDrive;
  } isr_state_t;

  isr_state_t st_r;
  isr_state_t st_nxt;

  logic               rise;
  logic               fall;
  logic               rxOn;
  logic               pop;
  logic               push;
  logic [4:0]         pos;
  logic [23:0]        word;
  logic signed [27:0] smpI;
  logic signed [27:0] smpQ;
  logic signed [27:0] mixI;
  logic signed [27:0] mixQ;
  logic signed [27:0] decI;
  logic signed [27:0] decQ;
  logic signed [27:0] diffA;
  logic signed [27:0] diffB;
  logic signed [27:0] hil;
  logic signed [27:0] sbv;
  logic signed [27:0] hpv;
  logic signed [27:0] lpv;

  function automatic logic signed [27:0] sx(input logic [23:0] v);
    sx = {{4{v[23]}}, v};
  endfunction

  assign rise = st_r.sclkSync[1] & ~st_r.sclkSync[2];
  assign fall = ~st_r.sclkSync[1] & st_r.sclkSync[2];
  assign rxOn = st_r.adcResetN & ~st_r.txDrive;
  assign pos  = st_r.bitCnt[4:0];
  assign word = {st_r.shift[22:0], st_r.sdataSync[1]};
  assign pop  = st_r.valid0 & audioReady;
  assign push = st_r.emitting & ~st_r.valid1;

  always_comb
  begin
    st_nxt = st_r;
    smpI   = sx(st_r.blk[st_r.rdIdx][47:24]);
    smpQ   = sx(st_r.blk[st_r.rdIdx][23:0]);
    mixI   = '0;
    mixQ   = '0;
    decI   = '0;
    decQ   = '0;
    diffA  = '0;
    diffB  = '0;
    hil    = '0;
    sbv    = '0;
    hpv    = '0;
    lpv    = '0;
    if (clkEn)
    begin
      st_nxt.sclkSync  = {st_r.sclkSync[1:0], bitClkPin};
      st_nxt.sdataSync = {st_r.sdataSync[0], serialDataPin};
      st_nxt.mclkAcc   = st_r.mclkAcc + MCLK_INC;
      st_nxt.txDrive   = txRequest;
      if (sidebandLoad)
      begin
        st_nxt.sbLsb = sidebandLower;
      end
      // converter reset held low once, then released for good
      if (!st_r.adcResetN)
      begin
        st_nxt.rstCnt = st_r.rstCnt + 8'h01;
        if (st_r.rstCnt == ADC_RST_LAST)
        begin
          st_nxt.adcResetN = 1'b1;
        end
      end
      // bit clock comes from the converter; only its edges are used
      if (fall)
      begin
        st_nxt.bitCnt   = st_r.bitCnt + 6'h01;
        st_nxt.frameClk = st_nxt.bitCnt[5];
      end
      if (rise && rxOn && pos >= DATA_FIRST && pos <= DATA_LAST)
      begin
        st_nxt.shift = word;
        if (pos == DATA_LAST)
        begin
          if (!st_r.bitCnt[5])
          begin
            st_nxt.iHold = word;
          end
          else
          begin
            st_nxt.blk[st_r.wrIdx] = {st_r.iHold, word};
            st_nxt.wrIdx = st_r.wrIdx + 5'h01;
            if (st_r.wrIdx == BLOCK_LAST)
            begin
              st_nxt.blkReady = 1'b1;
            end
          end
        end
      end
      if (st_r.blkReady && !st_r.processing && !st_r.emitting)
      begin
        st_nxt.processing = 1'b1;
        st_nxt.blkReady   = st_r.wrIdx == BLOCK_LAST && st_nxt.wrIdx == '0;
        st_nxt.rdIdx      = '0;
      end
      else if (st_r.processing && !st_r.emitting)
      begin
        // rotate by fs/4 so the signal lands on a 12 kHz carrier
        case (st_r.rdIdx[1:0])
          2'h0:
          begin
            mixI = smpI;
            mixQ = smpQ;
          end
          2'h1:
          begin
            mixI = -smpQ;
            mixQ = smpI;
          end
          2'h2:
          begin
            mixI = -smpI;
            mixQ = -smpQ;
          end
          default:
          begin
            mixI = smpQ;
            mixQ = -smpI;
          end
        endcase
        decI = st_r.accI + mixI;
        decQ = st_r.accQ + mixQ;
        st_nxt.accI  = decI;
        st_nxt.accQ  = decQ;
        st_nxt.rdIdx = st_r.rdIdx + 5'h01;
        if (st_r.rdIdx[1:0] == DECIM_LAST)
        begin
          // four-sample sum is the decimating low-pass
          st_nxt.accI  = '0;
          st_nxt.accQ  = '0;
          st_nxt.qHist = {st_r.qHist[5:0], decQ};
          st_nxt.iHist = {st_r.iHist[1:0], decI};
          diffA = decQ - $signed(st_r.qHist[5]);
          diffB = $signed(st_r.qHist[1]) - $signed(st_r.qHist[3]);
          // antisymmetric taps 1,3,-3,-1 against an I delay of three
          hil = (diffA + diffB + (diffB <<< 1)) >>> 2;
          if (st_r.sbLsb)
          begin
            sbv = $signed(st_r.iHist[2]) - hil;
          end
          else
          begin
            sbv = $signed(st_r.iHist[2]) + hil;
          end
          // dc block sets the low edge, one-pole smoother the high edge
          hpv = sbv - st_r.hpX + st_r.hpY - (st_r.hpY >>> HP_SHIFT);
          lpv = st_r.lpY + ((hpv - st_r.lpY) >>> LP_SHIFT);
          st_nxt.hpX       = sbv;
          st_nxt.hpY       = hpv;
          st_nxt.lpY       = lpv;
          st_nxt.outSample = lpv[OUT_LSB +: 24];
          st_nxt.emitting  = 1'b1;
          st_nxt.repCnt    = '0;
        end
        if (st_r.rdIdx == BLOCK_LAST)
        begin
          st_nxt.processing = 1'b0;
        end
      end
      // two-entry output buffer, head always in data0
      if (pop)
      begin
        st_nxt.data0  = st_r.data1;
        st_nxt.valid0 = st_r.valid1;
        st_nxt.valid1 = 1'b0;
      end
      if (push)
      begin
        if (!st_nxt.valid0)
        begin
          st_nxt.data0  = st_r.outSample;
          st_nxt.valid0 = 1'b1;
        end
        else
        begin
          st_nxt.data1  = st_r.outSample;
          st_nxt.valid1 = 1'b1;
        end
        st_nxt.repCnt = st_r.repCnt + 3'h1;
        if (st_r.repCnt == INTERP_LAST)
        begin
          st_nxt.emitting = 1'b0;
        end
      end
      if (st_r.txDrive)
      begin
        st_nxt.processing = 1'b0;
        st_nxt.emitting   = 1'b0;
        st_nxt.blkReady   = 1'b0;
        st_nxt.wrIdx      = '0;
        st_nxt.accI       = '0;
        st_nxt.accQ       = '0;
        st_nxt.valid0     = 1'b0;
        st_nxt.valid1     = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r       <= '0;
      st_r.sbLsb <= SIDEBAND_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign masterClk           = st_r.mclkAcc[31];
  assign leftRightFrameClock = st_r.frameClk;
  assign adcResetN           = st_r.adcResetN;
  assign txDriveEn           = st_r.txDrive;
  assign audioValid          = st_r.valid0;
  assign audioData           = st_r.data0;

  // helper: lower sideband only after software asked for it
  logic lsbAsked_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lsbAsked_r <= 1'b0;
    end
    else if (clkEn && sidebandLoad && sidebandLower)
    begin
      lsbAsked_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_mclk_toggles: assert property (clkEn ##1 clkEn ##1 1'b1 |->
    !(masterClk == $past(masterClk) && masterClk == $past(masterClk, 2)))
    else $error("master clock stuck");

  a_adc_reset_once: assert property (adcResetN |=> adcResetN)
    else $error("converter reset asserted again");
  a_adc_reset_len: assert property (
    $rose(adcResetN) |-> $past(st_r.rstCnt) == ADC_RST_LAST)
    else $error("converter reset pulse length wrong");

  a_frame_on_fall: assert property (
    $changed(leftRightFrameClock) |-> $past(fall && clkEn))
    else $error("frame clock moved off a bit clock fall");

  a_field_window: assert property (
    $changed(st_r.shift) |->
      $past(pos) >= DATA_FIRST && $past(pos) <= DATA_LAST
      && $past(rise))
    else $error("bit captured outside the 24-bit window");

  a_block_wrap: assert property (
    $rose(st_r.blkReady) |-> $past(st_r.wrIdx) == BLOCK_LAST)
    else $error("block flagged before 32 pairs");
  a_sideband_default: assert property (
    st_r.sbLsb |-> lsbAsked_r)
    else $error("lower sideband without request");

  a_tx_follows: assert property (
    clkEn |=> txDriveEn == $past(txRequest))
    else $error("transmit enable does not follow request");
  a_tx_no_audio: assert property (
    txDriveEn && clkEn |=> !audioValid && !st_r.processing)
    else $error("audio produced while transmitting");

  a_buf_hold: assert property (
    audioValid && !audioReady && !txDriveEn |=>
      audioValid && $stable(audioData))
    else $error("output word lost under stall");
  a_interp_bound: assert property (
    st_r.emitting |-> st_r.repCnt <= INTERP_LAST
      && (!$past(st_r.emitting) || $stable(st_r.outSample)))
    else $error("interpolated sample changed or overran");

  c_block_done: cover property ($fell(st_r.processing));
  c_buffer_full: cover property (st_r.valid1 && !audioReady);
  c_lower_out: cover property (st_r.sbLsb && push);
  c_tx_entry: cover property ($rose(txDriveEn) && audioValid);

endmodule

// file: tb/isr_adc_model.sv
// behavioural stereo converter acting as link master
`timescale 1ns/1ps
module isr_adc_model
  import isr_pkg::*;
(
  input  wire logic run,
  output logic      bitClk,
  output logic      serialData,
  output logic      field
);
  logic [10:0] cnt;
  logic [23:0] smp;

  // bit clock idles high until the bench lets the link run
  always
  begin
    bitClk = 1'b1;
    serialData = 1'b0;
    field = 1'b0;
    cnt = 11'h000;
    wait (run);
    forever
    begin
      #400;
      bitClk = 1'b0;
      cnt = cnt + 11'h001;
      field = cnt[5];
      smp = {cnt[10:6], 19'h00000};
      if (cnt[5])
        smp = smp ^ 24'h5a5a5a;
      // data moves on the fall, unused slots toggle every bit
      if (cnt[4:0] >= 5'h01 && cnt[4:0] <= 5'h18)
        serialData = smp[5'h18 - cnt[4:0]];
      else
        serialData = ~serialData;
      #400;
      bitClk = 1'b1;
    end
  end
endmodule

// file: tb/isr_receive_path_tb.sv
// self-checking bench for the serial-audio receive path
`timescale 1ns/1ps
module isr_receive_path_tb;
  import isr_pkg::*;
  logic        clk           = 1'b0;
  logic        reset_n       = 1'b0;
  logic        clkEn         = 1'b1;
  logic        txRequest     = 1'b0;
  logic        sidebandLoad  = 1'b0;
  logic        sidebandLower = 1'b0;
  logic        audioReady    = 1'b0;
  logic        run           = 1'b0;
  logic        bitClkPin;
  logic        serialDataPin;
  logic        field;
  logic        masterClk;
  logic        leftRightFrameClock;
  logic        adcResetN;
  logic        txDriveEn;
  logic        audioValid;
  logic [23:0] audioData;
  logic [23:0] words [2][32];
  int          fail_count    = 0;
  int          total_checks  = 0;

  always #50 clk = ~clk;

  isr_adc_model i_adc (
    .run        (run),
    .bitClk     (bitClkPin),
    .serialData (serialDataPin),
    .field      (field)
  );

  isr_receive_path i_dut (
    .clk                 (clk),
    .reset_n             (reset_n),
    .clkEn               (clkEn),
    .bitClkPin           (bitClkPin),
    .serialDataPin       (serialDataPin),
    .txRequest           (txRequest),
    .sidebandLoad        (sidebandLoad),
    .sidebandLower       (sidebandLower),
    .audioReady          (audioReady),
    .masterClk           (masterClk),
    .leftRightFrameClock (leftRightFrameClock),
    .adcResetN           (adcResetN),
    .txDriveEn           (txDriveEn),
    .audioValid          (audioValid),
    .audioData           (audioData)
  );

  task automatic check(input logic [23:0] seen, input logic [23:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic t_reset;
    int   cnt;
    int   gap;
    logic prev;
    cnt = 0;
    repeat (5) @(posedge clk);
    check(masterClk, 1'b0, "master clock in reset");
    check(leftRightFrameClock, 1'b0, "frame clock in reset");
    check(adcResetN, 1'b0, "converter reset in reset");
    check(txDriveEn, 1'b0, "transmit in reset");
    check(audioValid, 1'b0, "audio in reset");
    #1 reset_n = 1'b1;
    run = 1'b1;
    while (adcResetN !== 1'b1 && cnt < 50)
    begin
      @(posedge clk);
      #1 cnt++;
    end
    check(24'(cnt), 24'(ADC_RST_CYC), "converter reset length");
    prev = masterClk;
    cnt = 0;
    gap = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1 cnt = (masterClk !== prev) ? 0 : cnt + 1;
      prev = masterClk;
      gap = (cnt > gap) ? cnt : gap;
    end
    check(24'(gap < 3), 24'h000001, "master clock toggles");
    check(adcResetN, 1'b1, "converter reset stays off");
  endtask

  task automatic t_frame;
    repeat (70)
    begin
      @(posedge bitClkPin);
      check(leftRightFrameClock, field, "frame clock");
    end
  endtask

  task automatic t_block(input int b);
    int          n;
    int          w;
    logic        stall;
    logic [23:0] held;
    n = 0;
    w = 0;
    stall = 1'b0;
    while (audioValid !== 1'b1 && w < 20000)
    begin
      @(negedge clk);
      w++;
    end
    check(audioValid, 1'b1, "block produces audio");
    for (int k = 0; k < 400; k++)
    begin
      @(negedge clk);
      if (stall)
      begin
        check(audioValid, 1'b1, "valid held in stall");
        check(audioData, held, "data held in stall");
      end
      stall = audioValid === 1'b1 && audioReady !== 1'b1;
      held = audioData;
      if (audioValid === 1'b1 && audioReady === 1'b1)
      begin
        if (n < 32)
          words[b][n] = audioData;
        n++;
      end
      @(posedge clk);
      #1 audioReady = k >= 20 && k % 3 != 0;
    end
    check(24'(n), 24'h000020, "words per block");
    for (int i = 0; i < 32; i++)
      check(words[b][i], words[b][i & ~3], "repeat of four");
  endtask

  task automatic t_sideband;
    int d;
    d = 0;
    @(posedge clk);
    #1 sidebandLoad = 1'b1;
    sidebandLower = 1'b1;
    @(posedge clk);
    #1 sidebandLoad = 1'b0;
    t_block(1);
    for (int i = 0; i < 32; i++)
      d += (words[0][i] !== words[1][i]);
    check(24'(d != 0), 24'h000001, "sideband changes output");
  endtask

  task automatic t_tx;
    int k;
    k = 0;
    @(posedge clk);
    #1 txRequest = 1'b1;
    @(posedge clk);
    #1 check(txDriveEn, 1'b1, "transmit enable follows");
    clkEn = 1'b0;
    txRequest = 1'b0;
    repeat (4) @(posedge clk);
    #1 check(txDriveEn, 1'b1, "frozen while disabled");
    clkEn = 1'b1;
    txRequest = 1'b1;
    repeat (18000)
    begin
      @(negedge clk);
      if (audioValid === 1'b1)
        k++;
    end
    check(24'(k), 24'h000000, "no audio in transmit");
    @(posedge clk);
    #1 txRequest = 1'b0;
    @(posedge clk);
    #1 check(txDriveEn, 1'b0, "transmit enable drops");
  endtask

  initial
  begin
    #8_000_000;
    fail_count++;
    $display("BAD %0t watchdog ran out", $time);
    finish_test();
  end

  initial
  begin
    t_reset();
    t_frame();
    t_block(0);
    t_sideband();
    t_tx();
    finish_test();
  end
endmodule
